// ==== rtl/clcs_params.svh ====
// constants for the link control and status register bank
`ifndef CLCS_PARAMS_SVH
`define CLCS_PARAMS_SVH
`define CLCS_ADDR_W 27
`define CLCS_PCT_BASE 27'h0000000
`define CLCS_CSR_BASE 27'h0040000
`define CLCS_XMT_BASE 27'h0042000
`define CLCS_LINK_CONTROL_STATUS_OFF 27'h0040000
`define CLCS_RESET_VAL 32'h00000800
`define CLCS_B_TPE 0
`define CLCS_B_RPE 1
`define CLCS_B_VHUB 2
`define CLCS_B_RXE_EN 3
`define CLCS_B_TXE_EN 4
`define CLCS_B_MCI_EN 5
`define CLCS_B_PSC_EN 6
`define CLCS_B_MCI 7
`define CLCS_B_IFRST 8
`define CLCS_B_RXPEND 9
`define CLCS_B_TXPEND 10
`define CLCS_B_PUT 11
`define CLCS_B_RSV12 12
`define CLCS_B_LWONLY 13
`define CLCS_B_PSC 14
`define CLCS_B_ISUM 15
`define CLCS_B_ERRDIS 16
`define CLCS_B_ZDPAR 17
`define CLCS_B_CAPAR 18
`define CLCS_ONL_LO 19
`define CLCS_RW_MASK 32'h00073978
`define CLCS_W1C_MASK 32'h00004083
`endif

// ==== rtl/clcs_pkg.sv ====
// types for the link control and status register bank
package clcs_pkg;
    typedef enum logic [1:0] {
        CLCS_REG_PCT,
        CLCS_REG_CSR,
        CLCS_REG_XMT
    } clcs_region_type;

    typedef struct packed {
        logic [31:0] rdata;
        logic ack;
        logic pct_sel;
        logic xmt_sel;
        logic irq;
        logic link_ok;
        logic link_if_reset;
        logic ca_parity_out;
        logic data_parity_out;
        logic lw_only;
        logic fatal;
    } clcs_state_type;
endpackage : clcs_pkg

// ==== rtl/clcs_link_ctl.sv ====
// link control and status register bank with window decode
`include "clcs_params.svh"

module clcs_link_ctl (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic [26:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [7:0] port_online_i,
    input wire logic virtual_hub_i,
    input wire logic tx_fifo_nonempty_i,
    input wire logic rx_fifo_nonempty_i,
    input wire logic tx_path_error_i,
    input wire logic rx_path_error_i,
    input wire logic intr_page_write_i,
    input wire logic port_state_change_i,
    input wire logic heartbeat_timeout_i,
    input wire logic ca_parity_i,
    input wire logic data_parity_i,
    output logic [31:0] rdata_o,
    output logic ack_o,
    output logic pct_sel_o,
    output logic xmt_sel_o,
    output logic irq_o,
    output logic link_ok_o,
    output logic link_if_reset_o,
    output logic ca_parity_o,
    output logic data_parity_o,
    output logic lw_only_o,
    output logic fatal_o
);
    logic [31:0] csr;
    logic [31:0] next_csr;
    clcs_pkg::clcs_state_type st;
    clcs_pkg::clcs_state_type next_st;

    // window region of an offset
    function automatic clcs_pkg::clcs_region_type clcs_region(input logic [26:0] a);
        if (a < `CLCS_CSR_BASE) begin
            return clcs_pkg::CLCS_REG_PCT;
        end else if (a < `CLCS_XMT_BASE) begin
            return clcs_pkg::CLCS_REG_CSR;
        end
        return clcs_pkg::CLCS_REG_XMT;
    endfunction

    // readback value with live status fields
    function automatic logic [31:0] clcs_view(input logic [31:0] c, input logic [7:0] onl,
                                             input logic vh, input logic txp, input logic rxp);
        logic [31:0] v;
        v = c;
        v[26:`CLCS_ONL_LO] = vh ? 8'h00 : onl;
        v[`CLCS_B_TXPEND] = txp;
        v[`CLCS_B_RXPEND] = rxp;
        v[`CLCS_B_VHUB] = vh;
        v[31:27] = 5'h00;
        return v;
    endfunction

    // next state of register and outputs
    always_comb begin
        logic wr_csr;
        logic tpe_set;
        logic rpe_set;
        logic pend_tx;
        logic pend_rx;
        logic pend_mci;
        logic pend_psc;
        logic fatal_n;
        wr_csr = 1'b0;
        tpe_set = 1'b0;
        rpe_set = 1'b0;
        pend_tx = 1'b0;
        pend_rx = 1'b0;
        pend_mci = 1'b0;
        pend_psc = 1'b0;
        fatal_n = st.fatal;
        next_csr = csr;
        next_st = st;
        next_st.ack = 1'b0;
        next_st.pct_sel = 1'b0;
        next_st.xmt_sel = 1'b0;
        wr_csr = req_i && wr_i && (addr_i == `CLCS_LINK_CONTROL_STATUS_OFF);
        // write one to clear, read-write store
        if (wr_csr) begin
            next_csr = (csr & ~`CLCS_RW_MASK) | (wdata_i & `CLCS_RW_MASK);
            next_csr = next_csr & ~(wdata_i & `CLCS_W1C_MASK);
        end
        tpe_set = (tx_path_error_i || heartbeat_timeout_i) && !csr[`CLCS_B_ERRDIS];
        rpe_set = (rx_path_error_i || heartbeat_timeout_i) && !csr[`CLCS_B_ERRDIS];
        if (tpe_set) begin
            next_csr[`CLCS_B_TPE] = 1'b1;
        end
        if (rpe_set) begin
            next_csr[`CLCS_B_RPE] = 1'b1;
        end
        if (intr_page_write_i) begin
            next_csr[`CLCS_B_MCI] = 1'b1;
        end
        if (port_state_change_i && csr[`CLCS_B_PSC_EN]) begin
            next_csr[`CLCS_B_PSC] = 1'b1;
        end
        if (heartbeat_timeout_i) begin
            fatal_n = 1'b1;
        end
        if (next_csr[`CLCS_B_IFRST]) begin
            fatal_n = 1'b0;
        end
        next_st.fatal = fatal_n;
        pend_tx = next_csr[`CLCS_B_TPE] && next_csr[`CLCS_B_TXE_EN];
        pend_rx = next_csr[`CLCS_B_RPE] && next_csr[`CLCS_B_RXE_EN];
        pend_mci = next_csr[`CLCS_B_MCI] && next_csr[`CLCS_B_MCI_EN];
        pend_psc = next_csr[`CLCS_B_PSC] && next_csr[`CLCS_B_PSC_EN];
        next_csr[`CLCS_B_ISUM] = pend_tx || pend_rx || pend_mci || pend_psc;
        next_st.irq = next_csr[`CLCS_B_ISUM];
        // bus answer and region selects
        if (req_i) begin
            next_st.ack = 1'b1;
            unique case (clcs_region(addr_i))
                clcs_pkg::CLCS_REG_PCT: next_st.pct_sel = 1'b1;
                clcs_pkg::CLCS_REG_CSR: next_st.pct_sel = 1'b0;
                clcs_pkg::CLCS_REG_XMT: next_st.xmt_sel = 1'b1;
            endcase
            if (!wr_i && addr_i == `CLCS_LINK_CONTROL_STATUS_OFF) begin
                next_st.rdata = clcs_view(csr, port_online_i, virtual_hub_i,
                                          tx_fifo_nonempty_i, rx_fifo_nonempty_i);
            end else begin
                next_st.rdata = 32'h00000000;
            end
        end
        next_st.link_ok = !next_csr[`CLCS_B_PUT] && !fatal_n && !next_csr[`CLCS_B_IFRST];
        next_st.link_if_reset = next_csr[`CLCS_B_IFRST];
        next_st.ca_parity_out = ca_parity_i ^ next_csr[`CLCS_B_CAPAR];
        next_st.data_parity_out = data_parity_i && !next_csr[`CLCS_B_ZDPAR];
        next_st.lw_only = next_csr[`CLCS_B_LWONLY];
    end

    // state registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            csr <= `CLCS_RESET_VAL;
            st <= '0;
        end else begin
            csr <= next_csr;
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign rdata_o = st.rdata;
    assign ack_o = st.ack;
    assign pct_sel_o = st.pct_sel;
    assign xmt_sel_o = st.xmt_sel;
    assign irq_o = st.irq;
    assign link_ok_o = st.link_ok;
    assign link_if_reset_o = st.link_if_reset;
    assign ca_parity_o = st.ca_parity_out;
    assign data_parity_o = st.data_parity_out;
    assign lw_only_o = st.lw_only;
    assign fatal_o = st.fatal;
endmodule // clcs_link_ctl

// ==== tb/clcs_link_ctl_sva.sv ====
// port checker for the link control and status bank
module clcs_link_ctl_sva (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic [26:0] addr_i,
    input wire logic tx_fifo_nonempty_i,
    input wire logic rx_fifo_nonempty_i,
    input wire logic heartbeat_timeout_i,
    input wire logic [31:0] rdata_o,
    input wire logic ack_o,
    input wire logic pct_sel_o,
    input wire logic xmt_sel_o,
    input wire logic link_ok_o,
    input wire logic link_if_reset_o,
    input wire logic fatal_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // register read at the bank offset
    sequence s_csr_read;
        req_i && !wr_i && addr_i == 27'h0040000;
    endsequence
    // answers, decode, read view and link state
    chk_ack_pair: assert property (ack_o == $past(req_i)) else $error("ack not paired");
    chk_table_hit: assert property (req_i && addr_i < 27'h0040000 |=> pct_sel_o && !xmt_sel_o)
        else $error("table decode");
    chk_xmt_hit: assert property (req_i && addr_i >= 27'h0042000 |=> xmt_sel_o && !pct_sel_o)
        else $error("transmit decode");
    chk_high_zero: assert property (ack_o |-> rdata_o[31:27] == 5'h00) else $error("high bits set");
    chk_fifo_view: assert property (s_csr_read |=> rdata_o[10:9] ==
        $past({tx_fifo_nonempty_i, rx_fifo_nonempty_i})) else $error("fifo bits");
    chk_hb_fatal: assert property (heartbeat_timeout_i |=> fatal_o) else $error("no fatal");
    chk_fatal_down: assert property (fatal_o && $past(fatal_o) |-> !link_ok_o) else $error("link up");
    chk_ifrst_down: assert property (link_if_reset_o[*2] |-> !link_ok_o) else $error("link up in reset");
endmodule // clcs_link_ctl_sva

bind clcs_link_ctl clcs_link_ctl_sva u_sva (.*);

// ==== tb/clcs_far_model.sv ====
// far side model: link event pulses toward the bank
module clcs_far_model (
    input wire logic ref_clk_i,
    input wire logic [4:0] kick_i,
    output logic [4:0] pulse_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // kick copied to the pulses at each rising edge, one cycle later
    always_ff @(posedge ref_clk_i) begin
        pulse_o <= kick_i;
    end
endmodule // clcs_far_model

// ==== tb/tb.sv ====
// testbench for the link control and status bank
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, wr = 1'b0, vh = 1'b0, txf = 1'b1, rxf = 1'b0;
    logic [26:0] addr = 27'h0000000;
    logic [31:0] wd = 32'h00000000, rd, rdata;
    logic [4:0] kick = 5'h00, pulse;
    logic [1:0] sel;
    logic ack, ps, xs, irq, lok, lrst, cpo, dpo, lwo, fat;
    int error_cnt = 0, check_count = 0;
    initial begin
        forever #50 clk = ~clk;
    end
    clcs_link_ctl u_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .req_i(req), .wr_i(wr), .addr_i(addr), .wdata_i(wd),
        .port_online_i(8'hA5), .virtual_hub_i(vh), .tx_fifo_nonempty_i(txf), .rx_fifo_nonempty_i(rxf),
        .tx_path_error_i(pulse[0]), .rx_path_error_i(pulse[1]), .intr_page_write_i(pulse[2]),
        .port_state_change_i(pulse[3]), .heartbeat_timeout_i(pulse[4]), .ca_parity_i(1'b0), .data_parity_i(1'b1),
        .rdata_o(rdata), .ack_o(ack), .pct_sel_o(ps), .xmt_sel_o(xs), .irq_o(irq), .link_ok_o(lok),
        .link_if_reset_o(lrst), .ca_parity_o(cpo), .data_parity_o(dpo), .lw_only_o(lwo), .fatal_o(fat));
    clcs_far_model u_far (.ref_clk_i(clk), .kick_i(kick), .pulse_o(pulse));
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // one access, answer taken one cycle later
    task automatic acc(input logic w, input logic [26:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 req = 1'b1;
        wr = w;
        addr = a;
        wd = d;
        @(posedge clk);
        #1 req = 1'b0;
        cmp("ack", 32'h00000001, {31'h0, ack});
        rd = rdata;
        sel = {ps, xs};
    endtask
    // write the register, then read it back
    task automatic wrd(input logic [31:0] d, input logic [31:0] e);
        acc(1'b1, 27'h0040000, d);
        acc(1'b0, 27'h0040000, 32'h00000000);
        cmp("link_control_status", e, rd);
    endtask
    task automatic fire(input logic [4:0] k);
        @(posedge clk);
        #1 kick = k;
        @(posedge clk);
        #1 kick = 5'h00;
        repeat (2) @(posedge clk);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        acc(1'b0, 27'h0040000, 32'h00000000);
        cmp("reset", 32'h05280C00, rd);
        cmp("lok0", 32'h00000000, {31'h0, lok});
        wrd(32'hFFFEF6FF, 32'h052E3478);
        cmp("outs", 32'h0000000E, {28'h0, lwo, lok, cpo, dpo});
        fire(5'h0F);
        wrd(32'h00063078, 32'h052EF4FB);
        cmp("irq1", 32'h00000001, {31'h0, irq});
        wrd(32'h000670FB, 32'h052E3478);
        cmp("irq0", 32'h00000000, {31'h0, irq});
        wrd(32'h00063000, 32'h052E3400);
        fire(5'h0F);
        wrd(32'h00063000, 32'h052E3483);
        cmp("irqm", 32'h00000000, {31'h0, irq});
        wrd(32'h00073083, 32'h052F3400);
        fire(5'h13);
        wrd(32'h00073000, 32'h052F3400);
        cmp("fatal", 32'h00000002, {30'h0, fat, lok});
        acc(1'b1, 27'h0040000, 32'h00073100);
        cmp("ifrst", 32'h00000002, {30'h0, lrst, lok});
        acc(1'b1, 27'h0040000, 32'h00073000);
        cmp("relink", 32'h00000002, {29'h0, lrst, lok, fat});
        acc(1'b0, 27'h0000010, 32'h00000000);
        cmp("tsel", 32'h00000002, {30'h0, sel});
        acc(1'b0, 27'h0042000, 32'h00000000);
        cmp("xsel", 32'h00000001, {30'h0, sel});
        acc(1'b0, 27'h0041000, 32'h00000000);
        cmp("hole", 32'h00000000, {sel, rd[29:0]});
        vh = 1'b1;
        txf = 1'b0;
        rxf = 1'b1;
        wrd(32'h00073000, 32'h00073204);
        give_verdict();
    end
endmodule // tb
